// ==== rtl/ssp_port.sv ====
// Serial shift port: master or slave, full duplex, up to eight bytes.
// Assumes firmware strobes are one-cycle pulses on MCLK_IN.
`timescale 1ns/1ns
`include "ssp_params.svh"

// Contract
// RULE_01: Master role drives the serial clock out on its clock pin.
// RULE_02: Slave role shifts on the clock arriving from outside.
// RULE_03: One byte goes out while one byte comes in, same clocks.
// RULE_04: Works with three wires, or four with the select input.
// RULE_05: Serial bit rate never exceeds eight megabits per second.
// RULE_06: Each byte travels most significant bit first on both lines.
// RULE_07: Setting the go bit loads the shifter and starts the transfer.
// RULE_08: The go bit reads one during a transfer, cleared by hardware.
// RULE_09: At completion, data moves to receive buffer and both full flags set.
// RULE_10: Reading the receive buffer clears the full flag.
// RULE_11: Full flags set only at completion, otherwise cleared by firmware.
// RULE_12: Transmit buffer writes are ignored while a transfer shifts.
// RULE_13: Firmware must read received data before the next completes.
// RULE_14: When not selected the data input is disregarded.
// RULE_15: Slave role ignores edge select and rate select.
// RULE_16: Both ends should use the same rate and latching edge.
// RULE_17: Master holds select low from before first to after eighth clock; the port has no select output.
// RULE_18: With select high, slave ignores input and releases output.
// RULE_19: Select input used only in slave role with four wires.
// RULE_20: Full flags are status bits; edge and rate are control bits.
// RULE_21: Edge zero: out on rising, in on falling; one the reverse.
// RULE_22: Rate code picks divide 2 to 32, slave modes, or timer; codes 0 to 2 all divide by 14 here.
// RULE_23: Byte count sets bytes per transfer, at most eight.
// RULE_24: Slave sets overrun when new data lands on unread data.
// RULE_25: Reset clears go bit and full flags, no transfer running.
// RULE_26: Master gives eight clocks per byte, idle between transfers.
module ssp_port (
	input wire logic MCLK_IN,
	input wire logic RST_N_IN,
	input wire logic PORT_ON_IN,
	input wire logic EDGE_SELECT_IN,
	input wire logic [2:0] RATE_SELECT_IN,
	input wire logic [3:0] BYTE_COUNT_IN,
	input wire logic TIMER_TICK_IN,
	input wire logic SHIFT_GO_SET_IN,
	output logic SHIFT_GO_OUT,
	input wire logic TX_WR_IN,
	input wire logic [2:0] TX_WR_IDX_IN,
	input wire logic [7:0] TX_WR_DATA_IN,
	input wire logic RX_RD_IN,
	input wire logic [2:0] RX_RD_IDX_IN,
	output logic [7:0] RX_RD_DATA_OUT,
	input wire logic FULL_CLR_IN,
	input wire logic IRQ_CLR_IN,
	input wire logic OVERRUN_CLR_IN,
	output logic RX_BUFFER_FULL_OUT,
	output logic RX_FULL_IRQ_OUT,
	output logic READ_OVERRUN_OUT,
	input wire logic SCK_IN,
	output logic SCK_OUT,
	output logic SCK_OE_OUT,
	input wire logic SDI_IN,
	output logic SDO_OUT,
	output logic SDO_OE_OUT,
	input wire logic SS_N_IN
);

	// =====================================================
	// Helpers
	function automatic logic [2:0] last_index(input logic [3:0] cnt);
		logic [3:0] eff;
		eff = (cnt == 4'h0 || cnt > `SSP_BYTE_MAX) ? `SSP_BYTE_MAX : cnt;
		return 3'(eff - 4'h1);
	endfunction

	function automatic logic [4:0] half_limit(input logic [2:0] rate);
		logic [4:0] h;
		case (rate)
			`SSP_RATE_DIV2: h = 5'h01;
			`SSP_RATE_DIV4: h = 5'h02;
			`SSP_RATE_DIV8: h = 5'h04;
			`SSP_RATE_DIV16: h = 5'h08;
			default: h = 5'h10;
		endcase
		if (h < 5'(`SSP_MIN_HALF))
			h = 5'(`SSP_MIN_HALF);
		return h;
	endfunction

	// =====================================================
	// Declarations
	logic [7:0] tx_buf [0:7];
	logic [7:0] rx_buf [0:7];
	logic [7:0] rx_work [0:7];
	logic [63:0] tx_image;
	logic [63:0] slv_rx_image;
	logic [2:0] last_idx;
	logic shift_go;
	logic rx_buffer_full_flag;
	logic rx_full_irq_flag;
	logic overrun;
	ssp_pkg::ssp_state_t state;
	logic [7:0] shift_register;
	logic [7:0] rx_byte;
	logic [2:0] bit_cnt;
	logic [2:0] byte_idx;
	logic [4:0] half_cnt;
	logic [4:0] half_lim;
	logic phase;
	logic sck_q;
	logic sdo_q;
	logic tick_pend;
	logic expire;
	logic sdi_m1;
	logic sdi_m2;
	logic done_s1;
	logic done_s2;
	logic done_s3;
	logic slv_done_tgl;
	logic slv_sdo;
	logic is_slave;
	logic sel_used;
	logic selected;
	logic slv_sel_n;
	logic go_start;
	logic master_done;
	logic slave_done;
	logic done_evt;

	// =====================================================
	// Mode decode
	assign is_slave = RATE_SELECT_IN == `SSP_RATE_SLV_SEL ||
		RATE_SELECT_IN == `SSP_RATE_SLV_NOSEL; // see RULE_22
	assign sel_used = RATE_SELECT_IN == `SSP_RATE_SLV_SEL; // see RULE_19
	assign selected = !(sel_used && SS_N_IN); // see RULE_04
	// Slave shifter held in reset whenever it must not listen
	assign slv_sel_n = RST_N_IN && PORT_ON_IN && is_slave &&
		selected; // see RULE_14
	assign go_start = SHIFT_GO_SET_IN && PORT_ON_IN && !shift_go;
	assign master_done = state == ssp_pkg::ST_DONE;
	assign slave_done = done_s2 ^ done_s3;
	assign done_evt = master_done || slave_done;
	assign half_lim = half_limit(RATE_SELECT_IN); // see RULE_05
	assign expire = half_cnt >= half_lim - 5'h01 &&
		(RATE_SELECT_IN != `SSP_RATE_TIMER || tick_pend);

	// =====================================================
	// Pins
	assign SCK_OUT = sck_q; // see RULE_01
	assign SCK_OE_OUT = PORT_ON_IN && !is_slave;
	// Output released while deselected
	assign SDO_OUT = is_slave ? slv_sdo : sdo_q;
	assign SDO_OE_OUT = PORT_ON_IN &&
		(!is_slave || selected); // see RULE_18
	assign SHIFT_GO_OUT = shift_go; // see RULE_08
	assign RX_BUFFER_FULL_OUT = rx_buffer_full_flag;
	assign RX_FULL_IRQ_OUT = rx_full_irq_flag;
	assign READ_OVERRUN_OUT = overrun;

	// =====================================================
	// Synchronisers
	always_ff @(posedge MCLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			sdi_m1 <= 1'b0;
			sdi_m2 <= 1'b0;
		end else begin
			sdi_m1 <= SDI_IN;
			sdi_m2 <= sdi_m1;
		end
	end

	always_ff @(posedge MCLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			done_s1 <= 1'b0;
			done_s2 <= 1'b0;
			done_s3 <= 1'b0;
		end else begin
			done_s1 <= slv_done_tgl;
			done_s2 <= done_s1;
			done_s3 <= done_s2;
		end
	end

	// =====================================================
	// Transmit buffer
	always_ff @(posedge MCLK_IN) begin
		if (TX_WR_IN && !shift_go) // see RULE_12
			tx_buf[TX_WR_IDX_IN] <= TX_WR_DATA_IN;
	end

	// Image held still for the slave shifter during a transfer
	always_ff @(posedge MCLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			tx_image <= 64'h0000_0000_0000_0000;
			last_idx <= 3'h7;
		end else if (go_start) begin
			for (int i = 0; i < 8; i++)
				tx_image[(7 - i) * 8 +: 8] <= tx_buf[i];
			last_idx <= last_index(BYTE_COUNT_IN); // see RULE_23
		end
	end

	// =====================================================
	// Go bit
	always_ff @(posedge MCLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN)
			shift_go <= 1'b0; // see RULE_25
		else if (go_start)
			shift_go <= 1'b1; // see RULE_07
		else if (done_evt)
			shift_go <= 1'b0; // see RULE_08
	end

	// =====================================================
	// Status flags, set wins over clear
	always_ff @(posedge MCLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN)
			rx_buffer_full_flag <= 1'b0; // see RULE_25
		else if (done_evt)
			rx_buffer_full_flag <= 1'b1; // see RULE_09
		else if (RX_RD_IN || FULL_CLR_IN)
			rx_buffer_full_flag <= 1'b0; // see RULE_10
	end

	always_ff @(posedge MCLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN)
			rx_full_irq_flag <= 1'b0;
		else if (done_evt)
			rx_full_irq_flag <= 1'b1; // see RULE_20
		else if (IRQ_CLR_IN)
			rx_full_irq_flag <= 1'b0; // see RULE_11
	end

	always_ff @(posedge MCLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN)
			overrun <= 1'b0;
		else if (slave_done && rx_buffer_full_flag && !RX_RD_IN)
			overrun <= 1'b1; // see RULE_24
		else if (OVERRUN_CLR_IN)
			overrun <= 1'b0;
	end

	// =====================================================
	// Receive buffer
	always_ff @(posedge MCLK_IN) begin
		if (master_done) begin
			for (int i = 0; i < 8; i++)
				rx_buf[i] <= rx_work[i]; // see RULE_09
		end else if (slave_done) begin
			for (int i = 0; i < 8; i++)
				rx_buf[i] <= slv_rx_image[(7 - i) * 8 +: 8];
		end
	end

	always_ff @(posedge MCLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN)
			RX_RD_DATA_OUT <= 8'h00;
		else if (RX_RD_IN)
			RX_RD_DATA_OUT <= rx_buf[RX_RD_IDX_IN];
	end

	// =====================================================
	// Timer pacing
	always_ff @(posedge MCLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN)
			tick_pend <= 1'b0;
		else if (state == ssp_pkg::ST_SHIFT && expire)
			tick_pend <= 1'b0;
		else if (TIMER_TICK_IN)
			tick_pend <= 1'b1;
	end

	// =====================================================
	// Master engine state
	always_ff @(posedge MCLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			state <= ssp_pkg::ST_IDLE; // see RULE_25
		end else begin
			case (state)
				ssp_pkg::ST_IDLE: begin
					if (go_start && !is_slave)
						state <= ssp_pkg::ST_SHIFT;
				end
				ssp_pkg::ST_SHIFT: begin
					if (!PORT_ON_IN)
						state <= ssp_pkg::ST_IDLE;
					else if (expire && phase && bit_cnt == 3'h7 &&
						byte_idx == last_idx)
						state <= ssp_pkg::ST_DONE;
				end
				ssp_pkg::ST_DONE: state <= ssp_pkg::ST_IDLE;
				default: state <= ssp_pkg::ST_IDLE;
			endcase
		end
	end

	// =====================================================
	// Master serial clock and bit timing
	always_ff @(posedge MCLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			sck_q <= 1'b0;
			phase <= 1'b0;
			half_cnt <= 5'h00;
		end else if (state != ssp_pkg::ST_SHIFT) begin
			// Idle level chosen so the first edge is the out edge
			sck_q <= EDGE_SELECT_IN; // see RULE_16, RULE_21
			phase <= 1'b0;
			half_cnt <= 5'h00;
		end else if (expire) begin
			sck_q <= ~sck_q; // see RULE_26
			phase <= ~phase;
			half_cnt <= 5'h00;
		end else begin
			half_cnt <= half_cnt + 5'h01;
		end
	end

	// =====================================================
	// Master data path
	always_ff @(posedge MCLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			shift_register <= 8'h00;
			rx_byte <= 8'h00;
			sdo_q <= 1'b0;
			bit_cnt <= 3'h0;
			byte_idx <= 3'h0;
		end else if (state == ssp_pkg::ST_IDLE) begin
			bit_cnt <= 3'h0;
			byte_idx <= 3'h0;
			if (go_start)
				shift_register <= tx_buf[0]; // see RULE_07
		end else if (state == ssp_pkg::ST_SHIFT && expire) begin
			if (!phase) begin
				sdo_q <= shift_register[7]; // see RULE_06
				shift_register <= {shift_register[6:0], 1'b0};
			end else begin
				rx_byte <= {rx_byte[6:0], sdi_m2}; // see RULE_03
				bit_cnt <= bit_cnt + 3'h1;
				if (bit_cnt == 3'h7 && byte_idx != last_idx) begin
					byte_idx <= byte_idx + 3'h1;
					shift_register <= tx_buf[byte_idx + 3'h1];
				end
			end
		end
	end

	always_ff @(posedge MCLK_IN) begin
		if (state == ssp_pkg::ST_SHIFT && expire && phase &&
			bit_cnt == 3'h7)
			rx_work[byte_idx] <= {rx_byte[6:0], sdi_m2};
	end

	// =====================================================
	// Slave shifter on the far clock; edge and rate ignored there
	ssp_slave_link u_slave (
		.sck_in(SCK_IN), // see RULE_02
		.rst_n_in(RST_N_IN),
		.sel_n_in(slv_sel_n), // see RULE_15
		.tx_image_in(tx_image),
		.last_idx_in(last_idx),
		.sdi_in(SDI_IN),
		.sdo_out(slv_sdo),
		.done_tgl_out(slv_done_tgl),
		.rx_image_out(slv_rx_image)
	);

endmodule

// ==== common/ssp_params.svh ====
// Constants of the serial shift port: rates, modes, limits.
// Assumes a 100 MHz system clock on the master side.
`ifndef SSP_PARAMS_SVH
`define SSP_PARAMS_SVH

// =====================================================
// Timing
`define SSP_CLK_MHZ 100
`define SSP_MAX_MBPS 8
// Least half period of the serial clock, rounded up
`define SSP_MIN_HALF \
	((`SSP_CLK_MHZ + 2 * `SSP_MAX_MBPS - 1) / (2 * `SSP_MAX_MBPS))

// =====================================================
// Rate select codes
`define SSP_RATE_DIV2 3'h0
`define SSP_RATE_DIV4 3'h1
`define SSP_RATE_DIV8 3'h2
`define SSP_RATE_DIV16 3'h3
`define SSP_RATE_DIV32 3'h4
`define SSP_RATE_SLV_SEL 3'h5
`define SSP_RATE_SLV_NOSEL 3'h6
`define SSP_RATE_TIMER 3'h7

// =====================================================
// Sizes
`define SSP_BYTE_MAX 4'h8
`define SSP_IMAGE_W 64

`endif

// ==== common/ssp_pkg.sv ====
// Types of the serial shift port.
// Assumes ssp_params.svh is included by the users of the constants.
package ssp_pkg;

	// =====================================================
	// Master engine states, Gray from ST_IDLE to ST_DONE, two bits change on the return to ST_IDLE
	typedef enum logic [1:0] {
		ST_IDLE = 2'h0,
		ST_SHIFT = 2'h1,
		ST_DONE = 2'h3
	} ssp_state_t;

endpackage

// ==== rtl/ssp_slave_link.sv ====
// Slave-role shifter running on the serial clock from the far master.
// Assumes tx image and byte count stay still while a transfer runs.
`timescale 1ns/1ns

module ssp_slave_link (
	input wire logic sck_in,
	input wire logic rst_n_in,
	input wire logic sel_n_in,
	input wire logic [63:0] tx_image_in,
	input wire logic [2:0] last_idx_in,
	input wire logic sdi_in,
	output logic sdo_out,
	output logic done_tgl_out,
	output logic [63:0] rx_image_out
);

	logic [2:0] bit_cnt;
	logic [2:0] byte_idx;
	logic [5:0] bit_pos;

	// =====================================================
	// Bit position, most significant bit first
	// Byte 0 sits in the top byte of both images
	assign bit_pos = {~byte_idx, ~bit_cnt};
	assign sdo_out = tx_image_in[bit_pos];

	// =====================================================
	// Counters restart whenever the port is deselected
	always_ff @(posedge sck_in or negedge sel_n_in) begin
		if (!sel_n_in) begin
			bit_cnt <= 3'h0;
			byte_idx <= 3'h0;
		end else begin
			bit_cnt <= bit_cnt + 3'h1;
			if (bit_cnt == 3'h7) begin
				if (byte_idx == last_idx_in)
					byte_idx <= 3'h0;
				else
					byte_idx <= byte_idx + 3'h1;
			end
		end
	end

	// =====================================================
	// Received bits
	always_ff @(posedge sck_in or negedge rst_n_in) begin
		if (!rst_n_in)
			rx_image_out <= 64'h0000_0000_0000_0000;
		else if (sel_n_in)
			rx_image_out[bit_pos] <= sdi_in;
	end

	// =====================================================
	// Completion event, only the global reset clears it
	always_ff @(posedge sck_in or negedge rst_n_in) begin
		if (!rst_n_in)
			done_tgl_out <= 1'b0;
		else if (sel_n_in && bit_cnt == 3'h7 && byte_idx == last_idx_in)
			done_tgl_out <= ~done_tgl_out;
	end

endmodule

// ==== tb/ssp_port_monitor.sv ====
// Concurrent checks on the serial port's firmware and pin side.
// Assumes one system clock domain; bound onto ssp_port.
`timescale 1ns/1ns
`include "ssp_params.svh"

module ssp_port_monitor (
	input wire logic MCLK_IN,
	input wire logic RST_N_IN,
	input wire logic PORT_ON_IN,
	input wire logic EDGE_SELECT_IN,
	input wire logic [2:0] RATE_SELECT_IN,
	input wire logic SHIFT_GO_SET_IN,
	input wire logic SHIFT_GO_OUT,
	input wire logic RX_RD_IN,
	input wire logic FULL_CLR_IN,
	input wire logic IRQ_CLR_IN,
	input wire logic RX_BUFFER_FULL_OUT,
	input wire logic RX_FULL_IRQ_OUT,
	input wire logic SCK_OUT,
	input wire logic SCK_OE_OUT,
	input wire logic SDO_OE_OUT,
	input wire logic SS_N_IN
);
	default clocking cb @(posedge MCLK_IN);
	endclocking
	default disable iff (!RST_N_IN);

	// ========================================
	// Assertions
	chk_go_start:
	assert property (PORT_ON_IN && !SHIFT_GO_OUT && SHIFT_GO_SET_IN
		|=> SHIFT_GO_OUT) else $error("go bit not set");
	chk_go_done:
	assert property ($fell(SHIFT_GO_OUT) |-> ##[0:2] RX_BUFFER_FULL_OUT)
		else $error("go cleared without full flag");
	chk_flag_pair:
	assert property ($rose(RX_BUFFER_FULL_OUT) |-> RX_FULL_IRQ_OUT)
		else $error("full flags not set together");
	chk_full_keep:
	assert property (RX_BUFFER_FULL_OUT && !RX_RD_IN && !FULL_CLR_IN
		|=> RX_BUFFER_FULL_OUT) else $error("full flag dropped");
	chk_irq_keep:
	assert property (RX_FULL_IRQ_OUT && !IRQ_CLR_IN |=> RX_FULL_IRQ_OUT)
		else $error("irq flag dropped");
	chk_read_clear:
	assert property (RX_BUFFER_FULL_OUT && RX_RD_IN && !SHIFT_GO_OUT
		|=> !RX_BUFFER_FULL_OUT) else $error("read left full flag");
	chk_sck_half:
	assert property (SCK_OE_OUT && $changed(SCK_OUT)
		|=> $stable(SCK_OUT) [*6]) else $error("serial clock too fast");
	chk_sck_idle:
	assert property (!SHIFT_GO_OUT && !$past(SHIFT_GO_OUT) && SCK_OE_OUT
		&& $stable(EDGE_SELECT_IN) && $stable(PORT_ON_IN) && $past(RST_N_IN)
		|-> SCK_OUT == EDGE_SELECT_IN) else $error("clock not idle");
	chk_sck_dir:
	assert property ($stable(RATE_SELECT_IN) && $stable(PORT_ON_IN)
		|-> SCK_OE_OUT == (PORT_ON_IN
		&& RATE_SELECT_IN != `SSP_RATE_SLV_SEL
		&& RATE_SELECT_IN != `SSP_RATE_SLV_NOSEL))
		else $error("clock direction wrong");
	chk_sdo_off:
	assert property (RATE_SELECT_IN == `SSP_RATE_SLV_SEL && SS_N_IN
		&& $stable(SS_N_IN) && $stable(RATE_SELECT_IN) |-> !SDO_OE_OUT)
		else $error("data out driven while deselected");

	cover property ($rose(RX_BUFFER_FULL_OUT) && SCK_OE_OUT);
	cover property ($rose(RX_BUFFER_FULL_OUT) && !SCK_OE_OUT);
	cover property (SHIFT_GO_SET_IN && SHIFT_GO_OUT);
endmodule

bind ssp_port ssp_port_monitor mon (.*);

// ==== tb/ssp_far_end.sv ====
// Far SPI device: slave to our master, or master to our slave.
// Assumes the bench resolves the shared clock and data wires.
`timescale 1ns/1ns

module ssp_far_end (
	input wire logic sck_in,
	input wire logic sdo_in,
	input wire logic es_in,
	input wire logic slave_in,
	output logic sdi_out,
	output logic sck_out,
	output logic ss_n_out
);
	logic [63:0] tx;
	logic [63:0] rx;
	int edges;

	initial begin
		{sdi_out, sck_out, ss_n_out} = 3'h5;
		tx = '0;
		rx = '0;
		edges = 0;
	end

	task load(input logic [63:0] v);
		tx = v;
		rx = '0;
		edges = 0;
	endtask

	// Master role, clock only within frames
	task frame(input int nbits, input logic sel);
		ss_n_out = ~sel;
		#40;
		for (int i = 0; i < nbits; i++) begin
			sdi_out = tx[63];
			tx = {tx[62:0], ~tx[63]};
			#62;
			rx = {rx[62:0], sdo_in};
			sck_out = 1'b1;
			#63;
			sck_out = 1'b0;
		end
		#40;
		ss_n_out = 1'b1;
		sdi_out = ~sdi_out;
	endtask

	// Slave role: lead edge drives, trail edge samples
	always @(sck_in) begin
		if (slave_in) begin
			edges++;
			if (sck_in != es_in) begin
				sdi_out = tx[63];
				tx = {tx[62:0], ~tx[63]};
			end else begin
				rx = {rx[62:0], sdo_in};
			end
		end
	end
endmodule

// ==== tb/test_spi_master_slave_port.sv ====
// Self-checking bench for ssp_port against a far SPI device.
// Assumes ssp_port, ssp_far_end and the monitor are compiled first.
`timescale 1ns/1ns
`include "ssp_params.svh"

module test_spi_master_slave_port;
	logic mclk, rst_n, port_on, edge_sel, tick, go_set, tx_wr, rd;
	logic full_clr, irq_clr, ovr_clr, sdi, ss_n, far_sck;
	logic go, full, irq, ovr, sck_o, sck_oe, sdo_o, sdo_oe;
	logic [2:0] rate, tx_idx, rd_idx;
	logic [3:0] bcount;
	logic [7:0] tx_data, rd_data;
	int errors, check_count;
	wire sck_w = sck_oe ? sck_o : far_sck;
	wire sdo_w = sdo_oe ? sdo_o : 1'b1;
	wire far_slave = rate != `SSP_RATE_SLV_SEL && rate != `SSP_RATE_SLV_NOSEL;

	ssp_port uut (.MCLK_IN(mclk), .RST_N_IN(rst_n), .PORT_ON_IN(port_on),
		.EDGE_SELECT_IN(edge_sel), .RATE_SELECT_IN(rate),
		.BYTE_COUNT_IN(bcount), .TIMER_TICK_IN(tick),
		.SHIFT_GO_SET_IN(go_set), .SHIFT_GO_OUT(go), .TX_WR_IN(tx_wr),
		.TX_WR_IDX_IN(tx_idx), .TX_WR_DATA_IN(tx_data), .RX_RD_IN(rd),
		.RX_RD_IDX_IN(rd_idx), .RX_RD_DATA_OUT(rd_data),
		.FULL_CLR_IN(full_clr), .IRQ_CLR_IN(irq_clr),
		.OVERRUN_CLR_IN(ovr_clr), .RX_BUFFER_FULL_OUT(full),
		.RX_FULL_IRQ_OUT(irq), .READ_OVERRUN_OUT(ovr), .SCK_IN(sck_w),
		.SCK_OUT(sck_o), .SCK_OE_OUT(sck_oe), .SDI_IN(sdi),
		.SDO_OUT(sdo_o), .SDO_OE_OUT(sdo_oe), .SS_N_IN(ss_n));

	ssp_far_end far (.sck_in(sck_w), .sdo_in(sdo_w), .es_in(edge_sel),
		.slave_in(far_slave), .sdi_out(sdi), .sck_out(far_sck),
		.ss_n_out(ss_n));

	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end

	always begin
		repeat (9) @(negedge mclk);
		tick = 1'b1;
		@(negedge mclk);
		tick = 1'b0;
	end

	// ========================================
	// Tasks
	task chk(input string what, input logic [63:0] seen, exp);
		check_count++;
		if (seen !== exp) begin
			errors++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task test_done;
		$display("Checks %0d mismatches %0d", check_count, errors);
		if (errors == 0 && check_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	task wr(input logic [2:0] i, input logic [7:0] d);
		@(negedge mclk);
		{tx_wr, tx_idx, tx_data} = {1'b1, i, d};
		@(negedge mclk);
		tx_wr = 1'b0;
	endtask

	task start;
		@(negedge mclk);
		go_set = 1'b1;
		@(negedge mclk);
		go_set = 1'b0;
	endtask

	task wait_go;
		for (int k = 0; k < 20000 && go !== 1'b0; k++) @(negedge mclk);
		chk("go clear", go, 0);
		@(negedge mclk);
	endtask

	task xfer(input logic [2:0] r, input logic e, input int n, input logic w,
		input logic [63:0] img);
		logic [63:0] pimg;
		pimg = ~{img[35:0], img[63:36]};
		@(negedge mclk);
		{rate, edge_sel, bcount} = {r, e, 4'(n)};
		for (int i = 0; i < n; i++) if (w) wr(3'(i), img[63 - 8 * i -: 8]);
		repeat (3) @(negedge mclk);
		far.load(pimg);
		start();
		chk("go", go, 1);
		wr(3'h0, ~img[63:56]);
		if (!far_slave) far.frame(8 * n, 1'b1);
		wait_go();
		chk("flags", {full, irq}, 2'h3);
		chk("far rx", far.rx, img >> (64 - 8 * n));
		if (far_slave) chk("edges", far.edges, 16 * n);
		for (int i = 0; i < n; i++) begin
			@(negedge mclk);
			{rd, rd_idx} = {1'b1, 3'(i)};
			@(negedge mclk);
			rd = 1'b0;
			chk("rx byte", rd_data, pimg[63 - 8 * i -: 8]);
		end
		chk("read", {full, irq}, 2'h1);
		irq_clr = 1'b1;
		@(negedge mclk);
		irq_clr = 1'b0;
		chk("irq clr", irq, 0);
		$display("Transfer rate %0d bytes %0d done", r, n);
	endtask

	// ========================================
	// Main sequence
	initial begin
		{rst_n, port_on, edge_sel, tick, go_set, tx_wr, rd} = '0;
		{full_clr, irq_clr, ovr_clr, rate, tx_idx, rd_idx} = '0;
		{bcount, tx_data} = '0;
		errors = 0;
		check_count = 0;
		repeat (8) @(negedge mclk);
		rst_n = 1'b1;
		chk("reset", {go, full, irq, ovr}, 0);
		start();
		chk("go off", go, 0);
		$display("Reset and disabled start done");
		port_on = 1'b1;
		for (int k = 0; k < 6; k++)
			xfer(k < 5 ? 3'(k) : `SSP_RATE_TIMER, k[0], k < 5 ? k + 1 : 8,
				1'b1, 64'hC3A5_0F96_E17B_3D48 ^ 64'(k));
		xfer(3'h1, 1'b0, 3, 1'b0, 64'hC3A5_0F96_E17B_3D4D);
		xfer(`SSP_RATE_SLV_NOSEL, 1'b1, 2, 1'b1, 64'h1E2D_3C4B_5A69_7887);
		xfer(`SSP_RATE_SLV_SEL, 1'b0, 2, 1'b1, 64'h9F8E_7D6C_5B4A_3928);
		start();
		chk("sdo off", sdo_oe, 0);
		far.frame(16, 1'b0);
		repeat (6) @(negedge mclk);
		chk("ignored", {go, full}, 2'h2);
		far.frame(16, 1'b1);
		wait_go();
		start();
		far.frame(16, 1'b1);
		wait_go();
		chk("overrun", ovr, 1);
		{ovr_clr, full_clr} = 2'h3;
		@(negedge mclk);
		{ovr_clr, full_clr} = 2'h0;
		chk("flag clr", {ovr, full}, 0);
		$display("Slave select and overrun done");
		test_done();
	end

	initial begin
		#500000;
		errors++;
		test_done();
	end
endmodule
